// ==== core/dpc_power_ctrl.v ====
// Power state and reference mode controller of an octal DAC
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "dpc_regs.vh"

// Overview of operation
// - Update command or pin wakes powered-down channel
// - Wake-up coincides with output register update
// - Partial power-down wake: 12 us delay
// - Full chip power-down wake: 14 us delay
// - Bias off when all channels, reference down
// - External-select reference off: only 0110b restores
// - Chip-off reference: 0110b or wake restores
// - 0110b selects internal reference; reset default
// - 0111b selects external reference, pin input
// - 0100b powers down addressed channels only
// - 0101b powers down all channels, reference
// - Data word ignored by power-down commands
// - Channel registers kept during power-down
module dpc_power_ctrl
(
  input wire ref_clk_i,
  input wire reset_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire async_update_pin_n_i,
  output reg [31:0] rdata_o,
  output reg [7:0] chan_pd_o,
  output reg [7:0] chan_update_o,
  output reg [7:0] chan_settling_o,
  output reg bias_on_o,
  output reg ref_int_on_o,
  output reg ref_pin_oe_o,
  output reg settle_long_o
);

  // Channel selection from the 4-bit address field
  function [7:0] dpc_chan_sel;
    input [3:0] a;
    begin
      if (a == `DPC_ADDR_ALL)
        dpc_chan_sel = 8'hFF;
      else if (a[3] == 1'b0)
        dpc_chan_sel = 8'h01 << a[2:0];
      else
        dpc_chan_sel = 8'h00;
    end
  endfunction

  reg [7:0] pd_mask;
  reg ext_mode;
  reg chip_ref_off;
  reg [7:0] last_cmd;
  reg [7:0] woken;
  reg pin_meta;
  reg pin_sync;
  reg pin_prev;
  reg [7:0] next_pd_mask;
  reg [7:0] next_update;
  reg next_ext_mode;
  reg next_chip_ref_off;
  reg [7:0] wake_set;
  reg timer_start;
  reg timer_long;
  reg [7:0] sel;
  wire [3:0] cmd_code;
  wire [3:0] cmd_addr;
  wire cmd_go;
  wire pin_fall;
  wire ref_on;
  wire settle_busy;
  wire settle_long;

  assign cmd_code = wdata_i[`DPC_CMD_CODE_HI:`DPC_CMD_CODE_LO];
  assign cmd_addr = wdata_i[`DPC_CMD_ADDR_HI:`DPC_CMD_ADDR_LO];
  assign cmd_go = wr_i && (addr_i == `DPC_OFS_CMD);
  assign ref_on = ~ext_mode & ~chip_ref_off;

  // Pin is asynchronous: two flops before anything looks at it
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end
    else
    begin
      pin_meta <= async_update_pin_n_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Falling edge of the active-low pin updates every channel
  assign pin_fall = pin_prev & ~pin_sync;

  // Command decode; pin and command in one cycle merge their updates
  always @*
  begin
    sel = dpc_chan_sel(cmd_addr);
    next_pd_mask = pd_mask;
    next_update = 8'h00;
    next_ext_mode = ext_mode;
    next_chip_ref_off = chip_ref_off;
    if (cmd_go)
    begin
      case (cmd_code)
        `DPC_C_UPDATE, `DPC_C_WRITE_UPDATE:
          next_update = sel;
        `DPC_C_WRITE_UPD_ALL:
          next_update = 8'hFF;
        `DPC_C_PD_CHAN:
          next_pd_mask = pd_mask | sel;
        `DPC_C_PD_CHIP:
        begin
          next_pd_mask = 8'hFF;
          next_chip_ref_off = 1'b1;
        end
        `DPC_C_REF_INT:
        begin
          next_ext_mode = 1'b0;
          next_chip_ref_off = 1'b0;
        end
        `DPC_C_REF_EXT:
          next_ext_mode = 1'b1;
        default:
          next_update = 8'h00;
      endcase
    end
    if (pin_fall)
      next_update = next_update | 8'hFF;
    // Wake uses the mask before this update clears it
    wake_set = pd_mask & next_update;
    timer_start = (wake_set != 8'h00);
    timer_long = (pd_mask == 8'hFF) && !ref_on;
    if (next_update != 8'h00)
    begin
      next_pd_mask = next_pd_mask & ~next_update;
      if (wake_set != 8'h00)
        next_chip_ref_off = 1'b0;
    end
  end

  // State update; the data word never reaches these flops
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      pd_mask <= `DPC_RST_PDMASK;
      ext_mode <= 1'b0;
      chip_ref_off <= 1'b0;
      last_cmd <= `DPC_RST_CMD;
      woken <= 8'h00;
    end
    else
    begin
      pd_mask <= next_pd_mask;
      ext_mode <= next_ext_mode;
      chip_ref_off <= next_chip_ref_off;
      if (cmd_go)
        last_cmd <= {cmd_code, cmd_addr};
      if (timer_start)
        woken <= wake_set;
    end
  end

  dpc_settle_timer u_timer
  (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .start_i(timer_start),
    .long_i(timer_long),
    .busy_o(settle_busy),
    .long_o(settle_long)
  );

  // Outputs from flops; update pulse and wake land on the same edge
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      chan_pd_o <= `DPC_RST_PDMASK;
      chan_update_o <= 8'h00;
      bias_on_o <= 1'b1;
      ref_int_on_o <= 1'b1;
      ref_pin_oe_o <= 1'b1;
    end
    else
    begin
      chan_pd_o <= next_pd_mask;
      chan_update_o <= next_update;
      // Bias shuts down only when nothing at all is powered
      bias_on_o <= !((next_pd_mask == 8'hFF) && next_ext_mode == 1'b0
        && next_chip_ref_off == 1'b1) && !((next_pd_mask == 8'hFF)
        && next_ext_mode == 1'b1);
      ref_int_on_o <= ~next_ext_mode & ~next_chip_ref_off;
      // Pin drives only in internal mode; external mode is high-Z input
      ref_pin_oe_o <= ~next_ext_mode;
    end
  end

  // Settling flags follow the timer one cycle later
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      chan_settling_o <= 8'h00;
      settle_long_o <= 1'b0;
    end
    else
    begin
      chan_settling_o <= settle_busy ? woken : 8'h00;
      settle_long_o <= settle_busy & settle_long;
    end
  end

  // Register read: data stand in the cycle after the strobe only
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
      rdata_o <= 32'h00000000;
    else if (!rd_i)
      rdata_o <= 32'h00000000;
    else if (addr_i == `DPC_OFS_CMD)
      rdata_o <= {24'h000000, last_cmd};
    else if (addr_i == `DPC_OFS_STATUS)
      rdata_o <= {26'h0000000, settle_long & settle_busy, settle_busy,
        bias_on_o, chip_ref_off, ext_mode, ref_on};
    else if (addr_i == `DPC_OFS_PDMASK)
      rdata_o <= {24'h000000, pd_mask};
    else
      rdata_o <= 32'h00000000;
  end

endmodule

// ==== core/dpc_regs.vh ====
// Constants of the DAC power and reference controller
`ifndef DPC_REGS_VH
`define DPC_REGS_VH

// Register offsets (byte addresses)
`define DPC_OFS_CMD 4'h0
`define DPC_OFS_STATUS 4'h4
`define DPC_OFS_PDMASK 4'h8

// Command word layout in the command register
`define DPC_CMD_CODE_HI 23
`define DPC_CMD_CODE_LO 20
`define DPC_CMD_ADDR_HI 19
`define DPC_CMD_ADDR_LO 16

// Command codes
`define DPC_C_WRITE 4'h0
`define DPC_C_UPDATE 4'h1
`define DPC_C_WRITE_UPD_ALL 4'h2
`define DPC_C_WRITE_UPDATE 4'h3
`define DPC_C_PD_CHAN 4'h4
`define DPC_C_PD_CHIP 4'h5
`define DPC_C_REF_INT 4'h6
`define DPC_C_REF_EXT 4'h7

// Channel address meaning all channels
`define DPC_ADDR_ALL 4'hF

// Status register bit positions
`define DPC_ST_REF_ON 0
`define DPC_ST_EXT_MODE 1
`define DPC_ST_CHIP_REF_OFF 2
`define DPC_ST_BIAS_ON 3
`define DPC_ST_SETTLE_BUSY 4
`define DPC_ST_SETTLE_LONG 5

// Reset values
`define DPC_RST_PDMASK 8'h00
`define DPC_RST_CMD 8'h0F

// Power-up delays and their cycle counts at 50 MHz
`define DPC_CLK_MHZ 50
`define DPC_PU_SHORT_NS 12000
`define DPC_PU_LONG_NS 14000
`define DPC_PU_SHORT_CYC ((`DPC_PU_SHORT_NS * `DPC_CLK_MHZ + 999) / 1000)
`define DPC_PU_LONG_CYC ((`DPC_PU_LONG_NS * `DPC_CLK_MHZ + 999) / 1000)
`define DPC_TMR_W 10

`endif

// ==== core/dpc_settle_timer.v ====
// Power-up settling timer for woken channels
`timescale 1ns/10ps
`include "dpc_regs.vh"

module dpc_settle_timer
(
  input wire ref_clk_i,
  input wire reset_i,
  input wire start_i,
  input wire long_i,
  output reg busy_o,
  output reg long_o
);

  localparam integer SHORT_I = `DPC_PU_SHORT_CYC;
  localparam integer LONG_I = `DPC_PU_LONG_CYC;
  // Both counts fit the timer width; cut on purpose to that width
  localparam [`DPC_TMR_W-1:0] SHORT_CNT = SHORT_I[`DPC_TMR_W-1:0];
  localparam [`DPC_TMR_W-1:0] LONG_CNT = LONG_I[`DPC_TMR_W-1:0];
  localparam [`DPC_TMR_W-1:0] ONE = 10'h001;

  reg [`DPC_TMR_W-1:0] count;

  // A new start restarts the delay; busy lasts exactly the chosen count
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      count <= 10'h000;
      busy_o <= 1'b0;
      long_o <= 1'b0;
    end
    else if (start_i)
    begin
      count <= long_i ? LONG_CNT - ONE : SHORT_CNT - ONE;
      busy_o <= 1'b1;
      long_o <= long_i;
    end
    else if (count != 10'h000)
    begin
      count <= count - ONE;
    end
    else
    begin
      busy_o <= 1'b0;
    end
  end

endmodule

// ==== sim/dpc_power_ctrl_props.sv ====
// Port assertions of the power and reference controller
`timescale 1ns/10ps
module dpc_props
(
  input wire ref_clk_i,
  input wire reset_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire async_update_pin_n_i,
  input wire [31:0] rdata_o,
  input wire [7:0] chan_pd_o,
  input wire [7:0] chan_update_o,
  input wire [7:0] chan_settling_o,
  input wire bias_on_o,
  input wire ref_int_on_o,
  input wire ref_pin_oe_o,
  input wire settle_long_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Command decode; data half is never looked at
  wire w = wr_i && addr_i == 4'h0;
  wire [3:0] k = wdata_i[23:20];
  wire [3:0] n = wdata_i[19:16];
  wire [2:0] nc = wdata_i[18:16];
  AST_CHIP: assert property (
    w && k == 4'h5 |=> &chan_pd_o && !ref_int_on_o)
    else $error("chip power-down missed");
  AST_EXT: assert property (
    w && k == 4'h7 |=> !ref_pin_oe_o && !ref_int_on_o)
    else $error("external mode missed");
  AST_INT: assert property (
    w && k == 4'h6 |=> ref_int_on_o && ref_pin_oe_o)
    else $error("internal mode missed");
  AST_BIAS: assert property (
    bias_on_o == !(&chan_pd_o && !ref_int_on_o))
    else $error("bias state wrong");
  AST_UPD: assert property (
    w && k == 4'h3 && n == 4'hF
    |=> &chan_update_o && chan_pd_o == 8'h00)
    else $error("update all did not wake");
  AST_PD: assert property (
    w && k == 4'h4 && !n[3] && !chan_pd_o[nc]
    |=> $countones(chan_pd_o ^ $past(chan_pd_o)) == 1)
    else $error("channel power-down spread");
  AST_LONG: assert property (
    w && k == 4'h3 && n == 4'hF && &chan_pd_o && !ref_int_on_o
    |=> ##1 settle_long_o && &chan_settling_o)
    else $error("long delay missed");
  // Single-channel wake from partial power-down: channel index from two back
  AST_SHORT: assert property (
    w && (k == 4'h1 || k == 4'h3) && !n[3] && chan_pd_o[nc]
    && !(&chan_pd_o)
    |=> ##1 chan_settling_o[$past(nc, 2)] && !settle_long_o)
    else $error("short delay missed");
  // Main scenarios reached
  cover property (w && k == 4'h5);
  cover property ($rose(settle_long_o));
  cover property ($fell(async_update_pin_n_i));
endmodule
bind dpc_power_ctrl dpc_props chk (.*);

// ==== sim/dpc_pin_master.sv ====
// Host-side model that strobes the update pin
`timescale 1ns/10ps
module dpc_pin_master
(
  output reg async_update_pin_n_o
);
  // Idle high; edges fall at no fixed phase to the block clock
  initial async_update_pin_n_o = 1'b1;
  task strobe;
  begin
    #37 async_update_pin_n_o = 1'b0;
    #160 async_update_pin_n_o = 1'b1;
  end
  endtask
endmodule

// ==== sim/tb_top.sv ====
// Testbench of the power and reference controller
`timescale 1ns/10ps
`include "dpc_regs.vh"
module tb_top;
  reg ref_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  wire async_update_pin_n_i;
  wire [31:0] rdata_o;
  wire [7:0] chan_pd_o, chan_update_o, chan_settling_o;
  wire bias_on_o, ref_int_on_o, ref_pin_oe_o, settle_long_o;
  integer error_cnt = 0;
  integer total_checks = 0;
  integer ns, nl, i;
  // 50 MHz clock
  always #10 ref_clk_i = ~ref_clk_i;
  dpc_pin_master pm
  (
    .async_update_pin_n_o(async_update_pin_n_i)
  );
  dpc_power_ctrl uut
  (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .async_update_pin_n_i(async_update_pin_n_i),
    .rdata_o(rdata_o),
    .chan_pd_o(chan_pd_o),
    .chan_update_o(chan_update_o),
    .chan_settling_o(chan_settling_o),
    .bias_on_o(bias_on_o),
    .ref_int_on_o(ref_int_on_o),
    .ref_pin_oe_o(ref_pin_oe_o),
    .settle_long_o(settle_long_o)
  );
  task chk(input [31:0] a, input [31:0] e);
  begin
    total_checks = total_checks + 1;
    if (a !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  end
  endtask
  // Power and reference levels as {mask, ref, oe, bias}
  task st(input [10:0] e);
    chk({chan_pd_o, ref_int_on_o, ref_pin_oe_o, bias_on_o}, e);
  endtask
  // Whole command word; filler data must be ignored
  task cmd(input [7:0] c);
  begin
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= `DPC_OFS_CMD;
    wdata_i <= {8'h00, c, 16'hA5C3};
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  end
  endtask
  task rd(input [3:0] a, input [31:0] e);
  begin
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  end
  endtask
  // Counts settling and long-delay cycles over a fixed span
  task settle;
  begin
    ns = 0;
    nl = 0;
    for (i = 0; i < 800; i = i + 1)
    begin
      @(posedge ref_clk_i);
      #1;
      ns = ns + (|chan_settling_o);
      nl = nl + settle_long_o;
    end
  end
  endtask
  task test_done;
  begin
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    st({8'h00, 3'b111});
    rd(`DPC_OFS_STATUS, 32'h09);
    $display("test reset done");
    cmd(8'h42);
    st({8'h04, 3'b111});
    cmd(8'h48);
    st({8'h04, 3'b111});
    rd(`DPC_OFS_PDMASK, 32'h04);
    cmd(8'h32);
    chk(chan_update_o, 8'h04);
    st({8'h00, 3'b111});
    settle;
    chk(ns, 600);
    chk(nl, 0);
    $display("test partial wake done");
    cmd(8'h50);
    st({8'hFF, 3'b010});
    cmd(8'h3F);
    chk(chan_update_o, 8'hFF);
    st({8'h00, 3'b111});
    settle;
    chk(ns, 700);
    chk(nl, 700);
    $display("test chip wake done");
    cmd(8'h70);
    st({8'h00, 3'b001});
    cmd(8'h50);
    cmd(8'h3F);
    st({8'h00, 3'b001});
    settle;
    chk(ns, 700);
    chk(nl, 700);
    cmd(8'h60);
    st({8'h00, 3'b111});
    $display("test reference done");
    // Plain update and write-with-update-all codes also wake
    cmd(8'h43);
    st({8'h08, 3'b111});
    cmd(8'h13);
    chk(chan_update_o, 8'h08);
    st({8'h00, 3'b111});
    cmd(8'h45);
    cmd(8'h27);
    chk(chan_update_o, 8'hFF);
    st({8'h00, 3'b111});
    $display("test update codes done");
    cmd(8'h41);
    pm.strobe;
    for (i = 0; i < 20 && chan_pd_o !== 8'h00; i = i + 1)
      @(posedge ref_clk_i);
    #1;
    st({8'h00, 3'b111});
    rd(`DPC_OFS_STATUS, 32'h19);
    rd(`DPC_OFS_CMD, 32'h41);
    rd(4'hC, 32'h00);
    $display("test pin done");
    test_done;
  end
  // Hang guard well past the expected run
  initial
  begin
    #200000;
    error_cnt = error_cnt + 1;
    test_done;
  end
endmodule
